// file: hdl/cucc_pkg.sv
// Constants and types shared by both ends of the card command link.
// Frame offsets count from 3, as the byte-transport header is not covered.
package cucc_pkg;

  // ==========================================================
  // Command frame
  localparam logic [7:0] OFS_BASE = 8'h03;
  localparam logic [7:0] OFS_CLA = 8'h03;
  localparam logic [7:0] OFS_INS = 8'h04;
  localparam logic [7:0] OFS_P1 = 8'h05;
  localparam logic [7:0] OFS_P2 = 8'h06;
  localparam logic [7:0] OFS_LC = 8'h07;
  localparam logic [7:0] OFS_CMD_SEG = 8'h08;
  localparam logic [7:0] OFS_CTR_DATA = 8'h09;
  localparam logic [7:0] OFS_DR_LE = 8'h09;
  localparam logic [7:0] CLA_CODE = 8'h90;
  localparam logic [7:0] PARAM_ZERO = 8'h00;
  localparam logic [7:0] LC_DATA_REQ = 8'h01;
  localparam logic [7:0] LE_CODE = 8'h00;
  localparam logic [7:0] SEG_CENTER = 8'h00;
  // Instruction codes: arbitrary values, adjust to the target card.
  localparam logic [7:0] INS_DATA_REQ = 8'h5a;
  localparam logic [7:0] INS_CENTER = 8'h5b;
  localparam logic [7:0] INS_DATETIME = 8'h5c;
  localparam logic [7:0] INS_DEST = 8'h5d;

  // ==========================================================
  // Response frame
  localparam logic [7:0] OFS_UNIT_LEN = 8'h04;
  localparam logic [7:0] OFS_INSTR = 8'h05;
  localparam logic [7:0] OFS_RC = 8'h07;
  localparam logic [7:0] OFS_BODY = 8'h09;
  localparam logic [7:0] OFS_FINAL = 8'h0a;
  localparam logic [7:0] OFS_UPLOAD = 8'h0b;
  localparam logic [7:0] OFS_PHONE = 8'h11;
  localparam logic [7:0] OFS_DT_SW = 8'h0e;
  localparam logic [7:0] OFS_DEST_SW = 8'h18;
  localparam logic [7:0] UNIT_NUMBER = 8'h00;
  localparam logic [7:0] SW1_OK = 8'h90;
  localparam logic [7:0] SW2_OK = 8'h00;
  // Return codes: arbitrary values.
  localparam logic [15:0] RC_OK = 16'h2100;
  localparam logic [15:0] RC_SEQ_ERR = 16'ha1a0;
  localparam logic [15:0] RC_BAD_CMD = 16'ha1fe;
  localparam logic [7:0] SEG_HDR_LEN = 8'h02;
  localparam logic [7:0] DT_LEN = 8'h05;
  localparam logic [7:0] HOST_LEN = 8'h08;
  localparam logic [7:0] PHONE_LEN = 8'h07;
  localparam logic [3:0] PHONE_DIGITS = 4'he;
  localparam logic [3:0] NIB_INVALID = 4'hf;

  typedef enum logic [1:0] {
    K_DATA_REQ = 2'b00,
    K_CENTER = 2'b01,
    K_DATETIME = 2'b10,
    K_DEST = 2'b11
  } cucc_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX = 2'b01,
    ST_RX = 2'b10
  } cucc_state_t;

endpackage

// file: hdl/cucc_link_if.sv
// Byte link between the receiver (host) and the card.
// Both ends run on one clock; neither end can stall the other.
`timescale 1ns/10ps
`default_nettype none
interface cucc_link_if;
  logic cmd_valid;
  logic [7:0] cmd_data;
  logic cmd_last;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_last;
  modport host (
    output cmd_valid, cmd_data, cmd_last,
    input rsp_valid, rsp_data, rsp_last
  );
  modport card (
    input cmd_valid, cmd_data, cmd_last,
    output rsp_valid, rsp_data, rsp_last
  );
endinterface
`default_nettype wire

// file: hdl/cucc_card_end.sv
// Card end: interprets data request, center response, call-in date/time
// and call-in destination commands and streams the response frames.
// Assumes the host sends one command and waits for its whole response.
//
// Behaviour
// - Host sends data request n times.
// - Data request: 90, zero params, Lc 01.
// - Data request reply: header, segment fields, upload.
// - Host numbers data requests 1 up to n.
// - Out-of-order segment number gives sequence error.
// - Reply echoes k, final n, segment k.
// - Center response carries 00 plus n bytes.
// - Center reply: segment 00, final, upload.
// - Host asks date/time on card instruction.
// - Date/time command: Le 00 at offset 7.
// - Date/time reply: five bytes at 9.
// - Date/time as day number plus BCD.
// - Destination command has no data, Le 00.
// - Destination reply: host id, phone, status.
// - Host id is eight characters in order.
// - Phone number up to fourteen BCD digits.
// - Earlier digit in upper nibble.
// - Nibble F ends number and fills rest.
`timescale 1ns/10ps
`default_nettype none
module cucc_card_end (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  cucc_link_if.card link,
  input wire logic [15:0] i_card_instr,
  input wire logic [15:0] i_callin_mjd,
  input wire logic [23:0] i_callin_hms,
  input wire logic [63:0] i_host_id,
  input wire logic [55:0] i_phone_digits,
  input wire logic [3:0] i_phone_ndig,
  input wire logic [7:0] i_final_seg,
  input wire logic [7:0] i_seg_len,
  output logic [7:0] o_up_seg,
  output logic [7:0] o_up_idx,
  input wire logic [7:0] i_up_byte,
  output logic o_ctr_valid,
  output logic [7:0] o_ctr_byte,
  output logic o_seq_err
);

  // ==========================================================
  // State
  cucc_pkg::cucc_state_t state_ff;
  cucc_pkg::cucc_kind_t kind_ff;
  logic [7:0] ofs_ff;
  logic hdr_ok_ff;
  logic known_ff;
  logic [7:0] lc_ff;
  logic [7:0] seg_in_ff;
  logic [7:0] exp_ff;
  logic [7:0] final_ff;
  logic [7:0] rsp_seg_ff;
  logic [15:0] rc_ff;
  logic [7:0] body_ff;
  logic [7:0] tx_ofs_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_data_ff;
  logic rsp_last_ff;
  logic ctr_valid_ff;
  logic [7:0] ctr_byte_ff;
  logic seq_err_ff;

  logic cmd_take;
  logic cmd_end;
  logic [15:0] nxt_rc;
  logic [7:0] nxt_body;
  logic nxt_err;
  logic nxt_ok;
  logic [7:0] sw_ofs;
  logic tx_end;
  logic [55:0] phone_packed;
  logic [39:0] datetime;
  logic [7:0] rsp_byte;

  // Commands arriving while a response streams out are dropped; the host
  // is expected to wait for the status words.
  assign cmd_take = (state_ff == cucc_pkg::ST_IDLE) && link.cmd_valid;
  assign cmd_end = cmd_take && link.cmd_last;
  assign sw_ofs = cucc_pkg::OFS_BODY + body_ff;
  assign tx_end = (state_ff == cucc_pkg::ST_TX) &&
                  (tx_ofs_ff == sw_ofs + 8'h01);

  // ==========================================================
  // Command reception
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ofs_ff <= cucc_pkg::OFS_BASE;
      hdr_ok_ff <= 1'b0;
      known_ff <= 1'b0;
      kind_ff <= cucc_pkg::K_DATA_REQ;
      lc_ff <= 8'h00;
      seg_in_ff <= 8'h00;
    end else if (cmd_take) begin
      ofs_ff <= link.cmd_last ? cucc_pkg::OFS_BASE : ofs_ff + 8'h01;
      case (ofs_ff)
        cucc_pkg::OFS_CLA: begin
          hdr_ok_ff <= (link.cmd_data == cucc_pkg::CLA_CODE);
        end
        cucc_pkg::OFS_INS: begin
          known_ff <= 1'b1;
          case (link.cmd_data)
            cucc_pkg::INS_DATA_REQ: kind_ff <= cucc_pkg::K_DATA_REQ;
            cucc_pkg::INS_CENTER: kind_ff <= cucc_pkg::K_CENTER;
            cucc_pkg::INS_DATETIME: kind_ff <= cucc_pkg::K_DATETIME;
            cucc_pkg::INS_DEST: kind_ff <= cucc_pkg::K_DEST;
            default: known_ff <= 1'b0;
          endcase
        end
        cucc_pkg::OFS_P1, cucc_pkg::OFS_P2: begin
          if (link.cmd_data != cucc_pkg::PARAM_ZERO) begin
            hdr_ok_ff <= 1'b0;
          end
        end
        // for commands without data this byte is Le
        cucc_pkg::OFS_LC: lc_ff <= link.cmd_data;
        cucc_pkg::OFS_CMD_SEG: seg_in_ff <= link.cmd_data;
        default: ;
      endcase
    end
  end

  // center response bytes are handed to the card core as they arrive.
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ctr_valid_ff <= 1'b0;
      ctr_byte_ff <= 8'h00;
    end else begin
      ctr_valid_ff <= cmd_take && !link.cmd_last &&
                      (ofs_ff >= cucc_pkg::OFS_CTR_DATA) &&
                      (kind_ff == cucc_pkg::K_CENTER) && known_ff;
      ctr_byte_ff <= link.cmd_data;
    end
  end

  // ==========================================================
  // Command decision, made on the last command byte
  always_comb begin
    nxt_rc = cucc_pkg::RC_OK;
    nxt_body = 8'h00;
    nxt_err = 1'b0;
    nxt_ok = 1'b0;
    if (!hdr_ok_ff || !known_ff) begin
      nxt_rc = cucc_pkg::RC_BAD_CMD;
    end else begin
      case (kind_ff)
        cucc_pkg::K_DATA_REQ: begin
          if (lc_ff != cucc_pkg::LC_DATA_REQ) begin
            nxt_rc = cucc_pkg::RC_BAD_CMD;
          // only the next expected segment is served
          end else if (seg_in_ff == exp_ff && exp_ff != 8'h00 &&
                       exp_ff <= final_ff) begin
            nxt_ok = 1'b1;
            nxt_body = cucc_pkg::SEG_HDR_LEN + i_seg_len;
          end else begin
            nxt_rc = cucc_pkg::RC_SEQ_ERR;
            nxt_err = 1'b1;
          end
        end
        cucc_pkg::K_CENTER: begin
          if (seg_in_ff != cucc_pkg::SEG_CENTER) begin
            nxt_rc = cucc_pkg::RC_BAD_CMD;
          end else begin
            nxt_ok = 1'b1;
            nxt_body = cucc_pkg::SEG_HDR_LEN + i_seg_len;
          end
        end
        cucc_pkg::K_DATETIME: nxt_body = cucc_pkg::DT_LEN;
        cucc_pkg::K_DEST: nxt_body = cucc_pkg::HOST_LEN + cucc_pkg::PHONE_LEN;
        default: nxt_rc = cucc_pkg::RC_BAD_CMD;
      endcase
    end
  end

  // the expected segment advances only on a served request, so a
  // rejected request can be retried with the same number.
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      exp_ff <= 8'h00;
      final_ff <= 8'h00;
      seq_err_ff <= 1'b0;
    end else begin
      seq_err_ff <= cmd_end && nxt_err;
      if (cmd_end && nxt_ok) begin
        if (kind_ff == cucc_pkg::K_CENTER) begin
          exp_ff <= 8'h01;
          final_ff <= i_final_seg;
        end else begin
          exp_ff <= exp_ff + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Response framing
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_ff <= cucc_pkg::ST_IDLE;
      tx_ofs_ff <= cucc_pkg::OFS_BASE;
      rc_ff <= cucc_pkg::RC_OK;
      body_ff <= 8'h00;
      rsp_seg_ff <= 8'h00;
    end else begin
      case (state_ff)
        cucc_pkg::ST_IDLE: begin
          if (cmd_end) begin
            state_ff <= cucc_pkg::ST_TX;
            tx_ofs_ff <= cucc_pkg::OFS_BASE;
            rc_ff <= nxt_rc;
            body_ff <= nxt_body;
            // center reply always reports segment zero
            rsp_seg_ff <= (kind_ff == cucc_pkg::K_CENTER) ?
                          cucc_pkg::SEG_CENTER : seg_in_ff;
          end
        end
        cucc_pkg::ST_TX: begin
          tx_ofs_ff <= tx_ofs_ff + 8'h01;
          if (tx_end) begin
            state_ff <= cucc_pkg::ST_IDLE;
          end
        end
        default: state_ff <= cucc_pkg::ST_IDLE;
      endcase
    end
  end

  // digit pairs packed upper nibble first
  // positions past the digit count read as F, and all of them for a count above 14
  always_comb begin
    phone_packed = '1;
    for (int i = 0; i < 14; i++) begin
      if (4'(i) < i_phone_ndig && i_phone_ndig <= cucc_pkg::PHONE_DIGITS) begin
        phone_packed[55 - 4 * i -: 4] = i_phone_digits[55 - 4 * i -: 4];
      end else begin
        phone_packed[55 - 4 * i -: 4] = cucc_pkg::NIB_INVALID;
      end
    end
  end

  // day number first, then BCD hours, minutes, seconds
  assign datetime = {i_callin_mjd, i_callin_hms};

  // header, body and status words by frame offset
  always_comb begin
    rsp_byte = 8'h00;
    if (tx_ofs_ff == cucc_pkg::OFS_BASE) begin
      rsp_byte = cucc_pkg::UNIT_NUMBER;
    end else if (tx_ofs_ff == cucc_pkg::OFS_UNIT_LEN) begin
      rsp_byte = sw_ofs - cucc_pkg::OFS_INSTR;
    end else if (tx_ofs_ff < cucc_pkg::OFS_RC) begin
      rsp_byte = tx_ofs_ff[0] ? i_card_instr[15:8] : i_card_instr[7:0];
    end else if (tx_ofs_ff < cucc_pkg::OFS_BODY) begin
      rsp_byte = tx_ofs_ff[0] ? rc_ff[15:8] : rc_ff[7:0];
    end else if (tx_ofs_ff == sw_ofs) begin
      rsp_byte = cucc_pkg::SW1_OK;
    end else if (tx_ofs_ff > sw_ofs) begin
      rsp_byte = cucc_pkg::SW2_OK;
    end else begin
      case (kind_ff)
        cucc_pkg::K_DATETIME: begin
          rsp_byte = datetime[8 * (cucc_pkg::OFS_DT_SW - 1 - tx_ofs_ff) +: 8];
        end
        cucc_pkg::K_DEST: begin
          // host id from its first byte
          if (tx_ofs_ff < cucc_pkg::OFS_PHONE) begin
            rsp_byte = i_host_id[8 * (cucc_pkg::OFS_PHONE - 1 -
                                      tx_ofs_ff) +: 8];
          end else begin
            rsp_byte = phone_packed[8 * (cucc_pkg::OFS_DEST_SW - 1 -
                                         tx_ofs_ff) +: 8];
          end
        end
        default: begin
          // echo number, fixed final, upload segment
          if (tx_ofs_ff == cucc_pkg::OFS_BODY) begin
            rsp_byte = rsp_seg_ff;
          end else if (tx_ofs_ff == cucc_pkg::OFS_FINAL) begin
            rsp_byte = final_ff;
          end else begin
            rsp_byte = i_up_byte;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 8'h00;
      rsp_last_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= (state_ff == cucc_pkg::ST_TX);
      rsp_data_ff <= rsp_byte;
      rsp_last_ff <= tx_end;
    end
  end

  // The upload lookup is combinational: i_up_byte must follow
  // o_up_seg and o_up_idx in the same cycle.
  assign o_up_seg = rsp_seg_ff;
  assign o_up_idx = tx_ofs_ff - cucc_pkg::OFS_UPLOAD;
  assign o_ctr_valid = ctr_valid_ff;
  assign o_ctr_byte = ctr_byte_ff;
  assign o_seq_err = seq_err_ff;
  assign link.rsp_valid = rsp_valid_ff;
  assign link.rsp_data = rsp_data_ff;
  assign link.rsp_last = rsp_last_ff;

endmodule
`default_nettype wire

// file: hdl/cucc_host_end.sv
// Host end: sends one command on request and, after a center response,
// collects all upload segments with numbered data requests on its own.
// Assumes the card answers every complete command frame.
`timescale 1ns/10ps
`default_nettype none
module cucc_host_end (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  cucc_link_if.host link,
  input wire logic i_start,
  input wire logic [1:0] i_kind,
  input wire logic [7:0] i_ctr_len,
  output logic [7:0] o_ctr_idx,
  input wire logic [7:0] i_ctr_byte,
  output logic o_busy,
  output logic o_done,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_byte,
  output logic o_rsp_last,
  output logic [15:0] o_rc,
  output logic [3:0] o_phone_ndig
);

  // ==========================================================
  // State
  cucc_pkg::cucc_state_t state_ff;
  cucc_pkg::cucc_kind_t kind_ff;
  logic [7:0] ctr_len_ff;
  logic [7:0] tx_ofs_ff;
  logic [7:0] last_ofs_ff;
  logic [7:0] rx_ofs_ff;
  logic [7:0] seg_ff;
  logic [7:0] final_ff;
  logic [15:0] rc_ff;
  logic [3:0] ndig_ff;
  logic ndig_stop_ff;
  logic done_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_byte_ff;
  logic rsp_last_ff;
  logic [7:0] cmd_byte;
  logic rx_end;
  logic more;
  logic hi_ok;
  logic lo_ok;

  assign rx_end = (state_ff == cucc_pkg::ST_RX) && link.rsp_valid &&
                  link.rsp_last;
  // continue until n data requests are done
  assign more = (kind_ff == cucc_pkg::K_DATA_REQ ||
                 kind_ff == cucc_pkg::K_CENTER) &&
                rc_ff == cucc_pkg::RC_OK && seg_ff < final_ff;

  // ==========================================================
  // Sequencing
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_ff <= cucc_pkg::ST_IDLE;
      kind_ff <= cucc_pkg::K_CENTER;
      ctr_len_ff <= 8'h00;
      tx_ofs_ff <= cucc_pkg::OFS_BASE;
      last_ofs_ff <= cucc_pkg::OFS_LC;
      seg_ff <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        cucc_pkg::ST_IDLE: begin
          if (i_start && i_kind != cucc_pkg::K_DATA_REQ) begin
            state_ff <= cucc_pkg::ST_TX;
            kind_ff <= cucc_pkg::cucc_kind_t'(i_kind);
            ctr_len_ff <= i_ctr_len;
            tx_ofs_ff <= cucc_pkg::OFS_BASE;
            seg_ff <= 8'h00;
            // Le follows the n center bytes
            // no data field, Le at offset 7
            last_ofs_ff <= (i_kind == cucc_pkg::K_CENTER) ?
                           cucc_pkg::OFS_CTR_DATA + i_ctr_len :
                           cucc_pkg::OFS_LC;
          end
        end
        cucc_pkg::ST_TX: begin
          tx_ofs_ff <= tx_ofs_ff + 8'h01;
          if (tx_ofs_ff == last_ofs_ff) begin
            state_ff <= cucc_pkg::ST_RX;
          end
        end
        cucc_pkg::ST_RX: begin
          // next command only after the status words
          if (rx_end) begin
            if (more) begin
              // numbers rise by one from 1
              state_ff <= cucc_pkg::ST_TX;
              kind_ff <= cucc_pkg::K_DATA_REQ;
              seg_ff <= seg_ff + 8'h01;
              tx_ofs_ff <= cucc_pkg::OFS_BASE;
              last_ofs_ff <= cucc_pkg::OFS_DR_LE;
            end else begin
              state_ff <= cucc_pkg::ST_IDLE;
              done_ff <= 1'b1;
            end
          end
        end
        default: state_ff <= cucc_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Command bytes
  always_comb begin
    cmd_byte = cucc_pkg::LE_CODE;
    case (tx_ofs_ff)
      cucc_pkg::OFS_CLA: cmd_byte = cucc_pkg::CLA_CODE;
      cucc_pkg::OFS_INS: begin
        case (kind_ff)
          cucc_pkg::K_DATA_REQ: cmd_byte = cucc_pkg::INS_DATA_REQ;
          cucc_pkg::K_CENTER: cmd_byte = cucc_pkg::INS_CENTER;
          cucc_pkg::K_DATETIME: cmd_byte = cucc_pkg::INS_DATETIME;
          default: cmd_byte = cucc_pkg::INS_DEST;
        endcase
      end
      cucc_pkg::OFS_P1, cucc_pkg::OFS_P2: cmd_byte = cucc_pkg::PARAM_ZERO;
      cucc_pkg::OFS_LC: begin
        if (kind_ff == cucc_pkg::K_DATA_REQ) begin
          cmd_byte = cucc_pkg::LC_DATA_REQ;
        end else if (kind_ff == cucc_pkg::K_CENTER) begin
          cmd_byte = ctr_len_ff + 8'h01;
        end else begin
          cmd_byte = cucc_pkg::LE_CODE;
        end
      end
      cucc_pkg::OFS_CMD_SEG: begin
        cmd_byte = (kind_ff == cucc_pkg::K_DATA_REQ) ? seg_ff :
                   cucc_pkg::SEG_CENTER;
      end
      default: begin
        if (tx_ofs_ff != last_ofs_ff) begin
          cmd_byte = i_ctr_byte;
        end
      end
    endcase
  end

  assign link.cmd_valid = (state_ff == cucc_pkg::ST_TX);
  assign link.cmd_data = cmd_byte;
  assign link.cmd_last = (state_ff == cucc_pkg::ST_TX) &&
                         (tx_ofs_ff == last_ofs_ff);
  assign o_ctr_idx = tx_ofs_ff - cucc_pkg::OFS_CTR_DATA;

  // ==========================================================
  // Response capture
  assign hi_ok = !ndig_stop_ff && link.rsp_data[7:4] != cucc_pkg::NIB_INVALID;
  assign lo_ok = hi_ok && link.rsp_data[3:0] != cucc_pkg::NIB_INVALID;

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rx_ofs_ff <= cucc_pkg::OFS_BASE;
      rc_ff <= cucc_pkg::RC_OK;
      final_ff <= 8'h00;
      ndig_ff <= 4'h0;
      ndig_stop_ff <= 1'b0;
    end else if (state_ff == cucc_pkg::ST_TX) begin
      rx_ofs_ff <= cucc_pkg::OFS_BASE;
      if (kind_ff != cucc_pkg::K_DATA_REQ) begin
        final_ff <= 8'h00;
      end
      if (kind_ff == cucc_pkg::K_DEST) begin
        ndig_ff <= 4'h0;
        ndig_stop_ff <= 1'b0;
      end
    end else if (state_ff == cucc_pkg::ST_RX && link.rsp_valid) begin
      rx_ofs_ff <= rx_ofs_ff + 8'h01;
      if (rx_ofs_ff == cucc_pkg::OFS_RC) begin
        rc_ff[15:8] <= link.rsp_data;
      end
      if (rx_ofs_ff == cucc_pkg::OFS_RC + 8'h01) begin
        rc_ff[7:0] <= link.rsp_data;
      end
      if (rx_ofs_ff == cucc_pkg::OFS_FINAL &&
          kind_ff == cucc_pkg::K_CENTER) begin
        final_ff <= link.rsp_data;
      end
      // digits end at the first F nibble
      if (kind_ff == cucc_pkg::K_DEST && rx_ofs_ff >= cucc_pkg::OFS_PHONE &&
          rx_ofs_ff < cucc_pkg::OFS_DEST_SW) begin
        ndig_ff <= ndig_ff + {3'b000, hi_ok} + {3'b000, lo_ok};
        ndig_stop_ff <= !lo_ok;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      rsp_valid_ff <= 1'b0;
      rsp_byte_ff <= 8'h00;
      rsp_last_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= (state_ff == cucc_pkg::ST_RX) && link.rsp_valid;
      rsp_byte_ff <= link.rsp_data;
      rsp_last_ff <= rx_end;
    end
  end

  assign o_busy = (state_ff != cucc_pkg::ST_IDLE);
  assign o_done = done_ff;
  assign o_rsp_valid = rsp_valid_ff;
  assign o_rsp_byte = rsp_byte_ff;
  assign o_rsp_last = rsp_last_ff;
  assign o_rc = rc_ff;
  assign o_phone_ndig = ndig_ff;

endmodule
`default_nettype wire

// file: verif/cucc_link_monitor.sv
// Checker for the command and response bytes on the card link.
// Assumes one clock and an active-low synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module cucc_link_monitor (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_last
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================
  // Frame checks
  property p_le;
    cmd_last |-> cmd_valid && cmd_data == 8'h00;
  endproperty
  a_le: assert property (p_le)
    else $error("length byte wrong");
  property p_ans;
    cmd_last |-> ##2 rsp_valid && rsp_data == 8'h00;
  endproperty
  a_ans: assert property (p_ans)
    else $error("reply start wrong");
  property p_wait;
    rsp_valid |-> !cmd_valid;
  endproperty
  a_wait: assert property (p_wait)
    else $error("command during reply");
  property p_cla;
    $rose(cmd_valid) |-> cmd_data == cucc_pkg::CLA_CODE;
  endproperty
  a_cla: assert property (p_cla)
    else $error("class byte wrong");
  property p_dreq;
    $rose(cmd_valid) ##1 cmd_data == cucc_pkg::INS_DATA_REQ |=>
      cmd_data == 8'h00 ##1 cmd_data == 8'h00 ##1 cmd_data == 8'h01
      ##2 cmd_last;
  endproperty
  a_dreq: assert property (p_dreq)
    else $error("data request frame wrong");
  property p_dt;
    $rose(cmd_valid) ##1 cmd_data == cucc_pkg::INS_DATETIME |=>
      cmd_data == 8'h00 ##1 cmd_data == 8'h00 ##1 cmd_last;
  endproperty
  a_dt: assert property (p_dt)
    else $error("date request frame wrong");
  property p_ctr;
    $rose(cmd_valid) ##1 cmd_data == cucc_pkg::INS_CENTER |=>
      cmd_data == 8'h00 ##1 cmd_data == 8'h00 ##2 cmd_data == 8'h00;
  endproperty
  a_ctr: assert property (p_ctr)
    else $error("center frame wrong");
  property p_sw;
    rsp_last |-> rsp_data == 8'h00 && $past(rsp_data) == 8'h90;
  endproperty
  a_sw: assert property (p_sw)
    else $error("status words wrong");
endmodule
`default_nettype wire

// file: verif/tb_card_upload_callin_cmds.sv
// Bench joining host end and card end over the link.
// Assumes the host end builds every command frame itself.
`timescale 1ns/10ps
`default_nettype none
module tb_card_upload_callin_cmds;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic start = 1'b0, done, busy, rv, rl, ctr_v, seq_err;
  logic [1:0] kind = 2'b00;
  logic [3:0] ndig = 4'h0, pnd;
  logic [7:0] clen = 8'h01, cidx, cbyte, seg, idx, ubyte, rb, cb;
  logic [7:0] fin = 8'h00, m = 8'h00, cmem [256];
  logic [15:0] instr = 16'h0000, mjd = 16'h0000, rc;
  logic [23:0] hms = 24'h000000;
  logic [63:0] hid = 64'h0;
  logic [55:0] ph = 56'h0;
  logic [7:0] exp_q[$], got[$];
  int n_mismatch = 0, total_checks = 0, n_ctr = 0, n_seq = 0, n_last = 0;
  int t, i, j, r;
  cucc_link_if link ();
  initial forever #10 i_sys_clk = ~i_sys_clk;
  function automatic logic [7:0] upb(input logic [7:0] s, k);
    return s * 8'h1d + k ^ 8'h33;
  endfunction
  assign ubyte = upb(seg, idx);
  assign cbyte = cmem[cidx];
  cucc_host_end cucc_host_end_inst (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .link(link), .i_start(start), .i_kind(kind),
    .i_ctr_len(clen), .o_ctr_idx(cidx), .i_ctr_byte(cbyte), .o_busy(busy),
    .o_done(done), .o_rsp_valid(rv), .o_rsp_byte(rb), .o_rsp_last(rl),
    .o_rc(rc), .o_phone_ndig(pnd));
  cucc_card_end cucc_card_end_inst (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .link(link), .i_card_instr(instr),
    .i_callin_mjd(mjd), .i_callin_hms(hms), .i_host_id(hid),
    .i_phone_digits(ph), .i_phone_ndig(ndig), .i_final_seg(fin),
    .i_seg_len(m), .o_up_seg(seg), .o_up_idx(idx), .i_up_byte(ubyte),
    .o_ctr_valid(ctr_v), .o_ctr_byte(cb), .o_seq_err(seq_err));
  cucc_link_monitor cucc_link_monitor_inst (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .cmd_valid(link.cmd_valid),
    .cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
    .rsp_last(link.rsp_last));
  always @(negedge i_sys_clk) begin
    if (rv === 1'b1) got.push_back(rb);
    if (rl === 1'b1) n_last++;
    if (ctr_v === 1'b1) begin
      chk("center byte", 16'(cmem[n_ctr]), 16'(cb));
      n_ctr++;
    end
    if (seq_err === 1'b1) n_seq++;
  end
  // ==========================================================
  // Checking
  task automatic chk(input string nm, input logic [15:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hdr(input logic [7:0] len);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h04 + len);
    exp_q.push_back(instr[15:8]);
    exp_q.push_back(instr[7:0]);
    exp_q.push_back(8'h21);
    exp_q.push_back(8'h00);
  endtask
  task automatic run(input logic [1:0] k);
    got = {};
    n_ctr = 0;
    n_last = 0;
    exp_q.push_back(8'h90);
    exp_q.push_back(8'h00);
    kind = k;
    start = 1'b1;
    @(negedge i_sys_clk);
    start = 1'b0;
    chk("busy", 16'h1, 16'(busy));
    for (i = 0; i < 9000 && done !== 1'b1; i++) @(negedge i_sys_clk);
    if (done !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    @(negedge i_sys_clk);
    chk("reply length", 16'(exp_q.size()), 16'(got.size()));
    for (i = 0; i < exp_q.size(); i++)
      chk("reply byte", 16'(exp_q[i]), 16'(got[i]));
    chk("return code", 16'h2100, rc);
    chk("idle", 16'h0, 16'(busy));
    chk("reply ends", (k == 2'b01) ? 16'(fin + 8'h01) : 16'h1,
        16'(n_last));
    $display("test %0d kind %0d ended", t, k);
    exp_q = {};
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hdda22ad7));
    for (i = 0; i < 256; i++) cmem[i] = 8'($urandom);
    repeat (3) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    kind = 2'b00;
    start = 1'b1;
    @(negedge i_sys_clk);
    start = 1'b0;
    @(negedge i_sys_clk);
    chk("refused", 16'h0, 16'(busy));
    for (t = 0; t < 12; t++) begin
      if (t == 6) begin
        i_resetn = 1'b0;
        @(negedge i_sys_clk);
        i_resetn = 1'b1;
      end
      instr = 16'($urandom);
      r = (t < 6) ? t % 3 : $urandom % 3;
      if (r == 0) begin
        fin = (t == 3) ? 8'h03 : 8'($urandom % 4);
        m = (t == 0) ? 8'h00 : 8'($urandom % 6);
        clen = (t == 0) ? 8'h00 : 8'(1 + $urandom % 6);
        for (j = 0; j <= fin; j++) begin
          hdr(8'h02 + m);
          exp_q.push_back(8'(j));
          exp_q.push_back(fin);
          for (i = 0; i < m; i++) exp_q.push_back(upb(8'(j), 8'(i)));
          if (j < fin) exp_q.push_back(8'h90);
          if (j < fin) exp_q.push_back(8'h00);
        end
        run(2'b01);
        chk("center bytes", 16'(clen), 16'(n_ctr));
      end else if (r == 1) begin
        mjd = 16'($urandom);
        hms = {8'($urandom % 24), 8'($urandom % 60), 8'($urandom % 60)};
        hdr(8'h05);
        exp_q.push_back(mjd[15:8]);
        exp_q.push_back(mjd[7:0]);
        for (i = 2; i >= 0; i--) exp_q.push_back(hms[8*i +: 8]);
        run(2'b10);
      end else begin
        hid = {$urandom, $urandom};
        for (i = 0; i < 14; i++) ph[55-4*i -: 4] = 4'($urandom % 10);
        ndig = (t == 2) ? 4'he : (t == 5) ? 4'h0 : 4'($urandom % 15);
        hdr(8'h0f);
        for (i = 7; i >= 0; i--) exp_q.push_back(hid[8*i +: 8]);
        for (i = 0; i < 14; i += 2)
          exp_q.push_back({i < ndig ? ph[55-4*i -: 4] : 4'hf,
            i + 1 < ndig ? ph[51-4*i -: 4] : 4'hf});
        run(2'b11);
        chk("phone digits", 16'(ndig), 16'(pnd));
      end
    end
    chk("sequence errors", 16'h0000, 16'(n_seq));
    tally_and_finish();
  end
endmodule
`default_nettype wire
